// ==== design/rxrb_defs.vh ====
// constants for the receiver register bank and broadcast decoder
`ifndef RXRB_DEFS_VH
`define RXRB_DEFS_VH

// ----------------------------------------
// configuration word layout
// ----------------------------------------
`define RXRB_CFG_WIDTH 66
`define RXRB_CFG_BITS_W 7
`define RXRB_CFG_LAST_BIT 7'h41
`define RXRB_CFG_ID_MSB 13
`define RXRB_CFG_HAMMING_BIT 14
`define RXRB_CFG_CLKB_BIT 15
`define RXRB_CFG_REINIT_BIT 60

// ----------------------------------------
// internal subaddresses
// ----------------------------------------
`define RXRB_SUB_FINE_A 8'h00
`define RXRB_SUB_FINE_B 8'h01
`define RXRB_SUB_COARSE 8'h02
`define RXRB_SUB_CTRL 8'h03

// ----------------------------------------
// control register bits and reset values
// ----------------------------------------
`define RXRB_CTRL_CROSS_EN 0
`define RXRB_CTRL_TRIG_EN 1
`define RXRB_CTRL_SINGLE_INIT 3
`define RXRB_CTRL_FATAL_INIT 4
`define RXRB_CTRL_PAR_OFF 5
`define RXRB_CTRL_SER_BUS 6
`define RXRB_CTRL_RAW_CLK 7
`define RXRB_CTRL_RESET 8'h83
`define RXRB_COARSE_RESET 8'h00
`define RXRB_FINE_RESET 8'h00

// ----------------------------------------
// broadcast command field (bits 5:2)
// ----------------------------------------
`define RXRB_CMD_ERROR_DUMP 4'h1
`define RXRB_CMD_CONFIG_DUMP 4'h2
`define RXRB_CMD_REINIT 4'h4

// ----------------------------------------
// data qualifier codes
// ----------------------------------------
`define RXRB_DQ_DATA 4'h0
`define RXRB_DQ_ERR_FIRST 4'h1
`define RXRB_DQ_ERR_LAST 4'h4
`define RXRB_DQ_CFG_FIRST 4'h5
`define RXRB_DQ_CFG_LAST 4'hC

// ----------------------------------------
// counters and timing
// ----------------------------------------
`define RXRB_ERR_MAX 16'hFFFF
`define RXRB_PROM_HALF 8
`define RXRB_DELAY_TAPS 16

`endif

// ==== design/rxrb_core.v ====
// register bank, counters, broadcast decoder and dump sequencer of the receiver
//
// Behaviour
// - 66-bit config word shifted in from serial PROM, top bit first, id bit 0 last.
// - Config word is unreadable directly; its low 32 bits are dumped low byte first by config dump.
// - Control resets to 1,1,-,0,0,0,0,1 for bits 0 through 7.
// - With reinit enabled, control bits 3 and 4 let single or double errors reinit.
// - Control bit 5 forces data, qualifier, subaddress and data strobe outputs to zero.
// - Coarse bits 3:0 delay strobe a and counter resets; bits 7:4 delay strobe b.
// - Decoded broadcasts and trigger accept share the coarse delay in bits 3:0.
// - Two fine delay registers written at internal locations 0 and 1.
// - Each fine delay is 8 bits, steering a phased clock in about 104 ps steps.
// - 12-bit crossing counter counts every cycle while control bit 0 is set; cleared only by its command or init.
// - 24-bit trigger counter counts trigger accepts; cleared only by its command or init.
// - 16-bit counter counts corrected single errors; the frame is still acted on.
// - 16-bit counter counts double and stop-bit errors; that frame is discarded.
// - Error counters freeze at maximum; only reinitialisation clears them.
// - Broadcast low bits: 00 nothing, 01 crossing clear, 10 trigger clear, 11 both.
// - Broadcast bits 5:2: 1 error dump, 2 config dump, 3 reserved, 4 reinit.
// - Error dump: four bytes on consecutive cycles, qualifiers 1 to 4, strobed.
// - Config dump qualifiers: 5,6 fine, 7 coarse, 8 control, 9 to 12 config bytes.
// - Reinit broadcast warm restarts the logic and reloads the id from PROM.
// - Every broadcast drives the two user pins with its top two bits.
// - Broadcast bits 7:2 go to the bus; each strobe pulses once after its delay.
// - Internal frames write subaddress 0,1 fine, 2 coarse, 3 control.
`include "rxrb_defs.vh"

module rxrb_core #(
	parameter PROM_HALF = `RXRB_PROM_HALF,
	parameter DELAY_TAPS = `RXRB_DELAY_TAPS
) (
	input wire clk,
	input wire reset_n,
	input wire prom_data,
	output reg prom_reset,
	output reg prom_clk,
	input wire frame_valid,
	input wire frame_is_bcast,
	input wire [7:0] frame_bcast_data,
	input wire frame_ext,
	input wire [7:0] frame_subaddr,
	input wire [7:0] frame_data,
	input wire frame_single_err,
	input wire frame_fatal_err,
	input wire trigger_accept,
	output reg config_ready,
	output reg [13:0] rx_id,
	output reg hamming_enable,
	output reg phased_clock_b_enable,
	output reg raw_clock_enable,
	output reg serial_bus_enable,
	output reg [7:0] fine_delay_a,
	output reg [7:0] fine_delay_b,
	output reg [5:0] bcast_bus,
	output reg [1:0] user_bcast,
	output reg bcast_strobe_a,
	output reg bcast_strobe_b,
	output reg delayed_trigger,
	output reg [11:0] crossing_count,
	output reg [23:0] trigger_count,
	output reg [15:0] corrected_error_count,
	output reg [15:0] fatal_error_count,
	output reg [7:0] data_out,
	output reg [3:0] data_qual,
	output reg [7:0] out_subaddress,
	output reg out_byte_strobe
);

	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam [1:0] ST_PRESET = 2'b00;
	localparam [1:0] ST_LOAD = 2'b01;
	localparam [1:0] ST_RUN = 2'b10;

	reg [1:0] state_q;
	reg [7:0] div_q;
	reg [6:0] bit_cnt_q;
	reg prom_meta_q;
	reg prom_sync_q;
	reg [`RXRB_CFG_WIDTH-1:0] cfg_q;
	reg [7:0] ctrl_q;
	reg [7:0] coarse_q;
	reg dump_busy_q;
	reg [3:0] dump_qual_q;
	reg [9:0] line_q [0:DELAY_TAPS-1];

	wire running = (state_q == ST_RUN);
	wire div_tick = (div_q == PROM_HALF[7:0] - 8'h01);
	wire good_frame = frame_valid & running & ~frame_fatal_err;
	wire [9:0] tap_a = line_q[coarse_q[3:0]];
	wire [9:0] tap_b = line_q[coarse_q[7:4]];
	wire bc_a_valid = tap_a[8] & running;
	wire [7:0] bc_a = tap_a[7:0];
	wire bc_cmd_reinit = bc_a_valid & (bc_a[5:2] == `RXRB_CMD_REINIT);
	wire err_reinit = frame_valid & running & cfg_q[`RXRB_CFG_REINIT_BIT] &
		((ctrl_q[`RXRB_CTRL_SINGLE_INIT] & frame_single_err) |
		(ctrl_q[`RXRB_CTRL_FATAL_INIT] & frame_fatal_err));
	wire warm_init = bc_cmd_reinit | err_reinit;
	wire int_write = good_frame & ~frame_is_bcast & ~frame_ext;
	wire ext_write = good_frame & ~frame_is_bcast & frame_ext;
	wire dump_start_err = bc_a_valid & ~dump_busy_q & (bc_a[5:2] == `RXRB_CMD_ERROR_DUMP);
	wire dump_start_cfg = bc_a_valid & ~dump_busy_q & (bc_a[5:2] == `RXRB_CMD_CONFIG_DUMP);
	wire clear_cross = bc_a_valid & bc_a[0];
	wire clear_trig = bc_a_valid & bc_a[1];

	// ----------------------------------------
	// prom pin synchroniser
	// ----------------------------------------
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prom_meta_q <= 1'b0;
			prom_sync_q <= 1'b0;
		end else begin
			prom_meta_q <= prom_data;
			prom_sync_q <= prom_meta_q;
		end
	end

	// ----------------------------------------
	// init sequencer and prom shift-in
	// ----------------------------------------
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_PRESET;
			div_q <= 8'h00;
			bit_cnt_q <= 7'h00;
			prom_reset <= 1'b1;
			prom_clk <= 1'b0;
			config_ready <= 1'b0;
			cfg_q <= {`RXRB_CFG_WIDTH{1'b0}};
		end else if (warm_init) begin
			// warm restart: digital logic only, id reloaded
			state_q <= ST_PRESET;
			div_q <= 8'h00;
			bit_cnt_q <= 7'h00;
			prom_reset <= 1'b1;
			prom_clk <= 1'b0;
			config_ready <= 1'b0;
		end else begin
			div_q <= div_tick ? 8'h00 : div_q + 8'h01;
			case (state_q)
			ST_PRESET: begin
				if (div_tick) begin
					prom_reset <= 1'b0;
					state_q <= ST_LOAD;
				end
			end
			ST_LOAD: begin
				if (div_tick) begin
					prom_clk <= ~prom_clk;
					// sample at end of high phase, first bit lands in bit 65
					if (prom_clk) begin
						cfg_q <= {cfg_q[`RXRB_CFG_WIDTH-2:0], prom_sync_q};
						bit_cnt_q <= bit_cnt_q + 7'h01;
						if (bit_cnt_q == `RXRB_CFG_LAST_BIT) begin
							state_q <= ST_RUN;
							config_ready <= 1'b1;
						end
					end
				end
			end
			ST_RUN: begin
				prom_clk <= 1'b0;
			end
			default: begin
				state_q <= ST_PRESET;
			end
			endcase
		end
	end

	// config fields exported from the loaded word
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_id <= 14'h0000;
			hamming_enable <= 1'b0;
			phased_clock_b_enable <= 1'b0;
		end else begin
			rx_id <= cfg_q[`RXRB_CFG_ID_MSB:0];
			hamming_enable <= cfg_q[`RXRB_CFG_HAMMING_BIT];
			phased_clock_b_enable <= cfg_q[`RXRB_CFG_CLKB_BIT];
		end
	end

	// ----------------------------------------
	// internal registers written by frames
	// ----------------------------------------
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q <= `RXRB_CTRL_RESET;
			coarse_q <= `RXRB_COARSE_RESET;
			fine_delay_a <= `RXRB_FINE_RESET;
			fine_delay_b <= `RXRB_FINE_RESET;
		end else if (warm_init) begin
			ctrl_q <= `RXRB_CTRL_RESET;
			coarse_q <= `RXRB_COARSE_RESET;
			fine_delay_a <= `RXRB_FINE_RESET;
			fine_delay_b <= `RXRB_FINE_RESET;
		end else if (int_write) begin
			// subaddress decode
			case (frame_subaddr)
			`RXRB_SUB_FINE_A: fine_delay_a <= frame_data;
			`RXRB_SUB_FINE_B: fine_delay_b <= frame_data;
			`RXRB_SUB_COARSE: coarse_q <= frame_data;
			`RXRB_SUB_CTRL: ctrl_q <= frame_data;
			default: ctrl_q <= ctrl_q;
			endcase
		end
	end

	// control bits driven out
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			raw_clock_enable <= 1'b1;
			serial_bus_enable <= 1'b0;
		end else begin
			raw_clock_enable <= ctrl_q[`RXRB_CTRL_RAW_CLK];
			serial_bus_enable <= ctrl_q[`RXRB_CTRL_SER_BUS];
		end
	end

	// ----------------------------------------
	// coarse delay line: {trigger, bcast valid, bcast byte}
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < DELAY_TAPS; gi = gi + 1) begin : g_line
			always @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					line_q[gi] <= 10'h000;
				end else if (gi == 0) begin
					// corrected frames still act, fatal ones are dropped
					line_q[gi] <= {trigger_accept, good_frame & frame_is_bcast, frame_bcast_data};
				end else begin
					line_q[gi] <= line_q[(gi > 0) ? gi - 1 : 0];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// broadcast outputs after deskew
	// ----------------------------------------
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bcast_bus <= 6'h00;
			user_bcast <= 2'b00;
			bcast_strobe_a <= 1'b0;
			bcast_strobe_b <= 1'b0;
			delayed_trigger <= 1'b0;
		end else begin
			// message and trigger share the bits 3:0 delay
			bcast_strobe_a <= bc_a_valid;
			bcast_strobe_b <= tap_b[8] & running;
			delayed_trigger <= tap_a[9];
			if (bc_a_valid) begin
				bcast_bus <= bc_a[7:2];
				user_bcast <= bc_a[7:6];
			end
		end
	end

	// ----------------------------------------
	// crossing and trigger counters
	// ----------------------------------------
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			crossing_count <= 12'h000;
			trigger_count <= 24'h000000;
		end else if (warm_init) begin
			crossing_count <= 12'h000;
			trigger_count <= 24'h000000;
		end else begin
			// clear command wins over counting
			if (clear_cross) begin
				crossing_count <= 12'h000;
			end else if (ctrl_q[`RXRB_CTRL_CROSS_EN]) begin
				crossing_count <= crossing_count + 12'h001;
			end
			if (clear_trig) begin
				trigger_count <= 24'h000000;
			end else if (ctrl_q[`RXRB_CTRL_TRIG_EN] & tap_a[9]) begin
				trigger_count <= trigger_count + 24'h000001;
			end
		end
	end

	// ----------------------------------------
	// error counters, saturating
	// ----------------------------------------
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			corrected_error_count <= 16'h0000;
			fatal_error_count <= 16'h0000;
		end else if (warm_init) begin
			corrected_error_count <= 16'h0000;
			fatal_error_count <= 16'h0000;
		end else if (frame_valid & running) begin
			if (frame_single_err & (corrected_error_count != `RXRB_ERR_MAX)) begin
				corrected_error_count <= corrected_error_count + 16'h0001;
			end
			if (frame_fatal_err & (fatal_error_count != `RXRB_ERR_MAX)) begin
				fatal_error_count <= fatal_error_count + 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// dump sequencer
	// ----------------------------------------
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dump_busy_q <= 1'b0;
			dump_qual_q <= `RXRB_DQ_DATA;
		end else if (warm_init) begin
			dump_busy_q <= 1'b0;
			dump_qual_q <= `RXRB_DQ_DATA;
		end else if (dump_start_err) begin
			dump_busy_q <= 1'b1;
			dump_qual_q <= `RXRB_DQ_ERR_FIRST;
		end else if (dump_start_cfg) begin
			dump_busy_q <= 1'b1;
			dump_qual_q <= `RXRB_DQ_CFG_FIRST;
		end else if (dump_busy_q) begin
			// one byte per cycle, stop after last qualifier
			if ((dump_qual_q == `RXRB_DQ_ERR_LAST) || (dump_qual_q == `RXRB_DQ_CFG_LAST)) begin
				dump_busy_q <= 1'b0;
				dump_qual_q <= `RXRB_DQ_DATA;
			end else begin
				dump_qual_q <= dump_qual_q + 4'h1;
			end
		end
	end

	// byte selected by the current qualifier
	reg [7:0] dump_byte;
	always @* begin
		dump_byte = 8'h00;
		case (dump_qual_q)
		4'h1: dump_byte = corrected_error_count[15:8];
		4'h2: dump_byte = corrected_error_count[7:0];
		4'h3: dump_byte = fatal_error_count[15:8];
		4'h4: dump_byte = fatal_error_count[7:0];
		4'h5: dump_byte = fine_delay_a;
		4'h6: dump_byte = fine_delay_b;
		4'h7: dump_byte = coarse_q;
		4'h8: dump_byte = ctrl_q;
		4'h9: dump_byte = cfg_q[7:0]; // low byte first
		4'hA: dump_byte = cfg_q[15:8];
		4'hB: dump_byte = cfg_q[23:16];
		4'hC: dump_byte = cfg_q[31:24];
		default: dump_byte = 8'h00;
		endcase
	end

	// ----------------------------------------
	// external data bus
	// ----------------------------------------
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			data_out <= 8'h00;
			data_qual <= 4'h0;
			out_subaddress <= 8'h00;
			out_byte_strobe <= 1'b0;
		end else if (ctrl_q[`RXRB_CTRL_PAR_OFF]) begin
			// bus forced to zero
			data_out <= 8'h00;
			data_qual <= 4'h0;
			out_subaddress <= 8'h00;
			out_byte_strobe <= 1'b0;
		end else if (dump_busy_q) begin
			data_out <= dump_byte;
			data_qual <= dump_qual_q;
			out_byte_strobe <= 1'b1;
		end else if (ext_write) begin
			data_out <= frame_data;
			data_qual <= `RXRB_DQ_DATA;
			out_subaddress <= frame_subaddr;
			out_byte_strobe <= 1'b1;
		end else begin
			out_byte_strobe <= 1'b0;
		end
	end

endmodule

// ==== testbench/rxrb_core_assertions.sv ====
// port checks for the receiver register bank
module rxrb_core_assertions #(
	parameter PROM_HALF = 8,
	parameter DELAY_TAPS = 16
) (
	input wire clk,
	input wire reset_n,
	input wire prom_clk,
	input wire frame_valid,
	input wire frame_is_bcast,
	input wire frame_ext,
	input wire [7:0] frame_subaddr,
	input wire [7:0] frame_data,
	input wire frame_single_err,
	input wire frame_fatal_err,
	input wire config_ready,
	input wire [5:0] bcast_bus,
	input wire [1:0] user_bcast,
	input wire bcast_strobe_a,
	input wire delayed_trigger,
	input wire [11:0] crossing_count,
	input wire [23:0] trigger_count,
	input wire [15:0] corrected_error_count,
	input wire [15:0] fatal_error_count,
	input wire [7:0] data_out,
	input wire [3:0] data_qual,
	input wire [7:0] out_subaddress,
	input wire out_byte_strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// ----------------------------------------
	// dump sequencing, external bytes and user pins
	// ----------------------------------------
	sequence next_byte;
		out_byte_strobe && data_qual == $past(data_qual) + 4'h1;
	endsequence
	a_dump_byte_step: assert property (
		out_byte_strobe && data_qual inside {[1:3], [5:11]} |=> next_byte)
		else $error("dump qualifier did not advance");
	a_ext_frame_out: assert property (
		out_byte_strobe && data_qual == 4'h0
		|-> $past(frame_valid && frame_ext && !frame_is_bcast)
		&& data_out == $past(frame_data) && out_subaddress == $past(frame_subaddr))
		else $error("external byte not from the frame");
	a_user_pins_track: assert property (
		bcast_strobe_a |-> user_bcast == bcast_bus[5:4])
		else $error("user pins differ from broadcast bus");

	// ----------------------------------------
	// counters
	// ----------------------------------------
	a_cross_step: assert property (
		crossing_count == 12'h000 || crossing_count - $past(crossing_count) <= 12'h001)
		else $error("crossing counter jumped");
	// the counter and the delayed trigger are updated at the same edge
	a_trig_step: assert property (
		trigger_count != $past(trigger_count) && trigger_count != 24'h0
		|-> trigger_count == $past(trigger_count) + 24'h1 && delayed_trigger)
		else $error("trigger counter step without trigger");
	a_single_sat: assert property (
		corrected_error_count == 16'hFFFF
		|=> corrected_error_count == 16'hFFFF || corrected_error_count == 16'h0000)
		else $error("corrected count left its maximum");
	a_fatal_sat: assert property (
		fatal_error_count == 16'hFFFF
		|=> fatal_error_count == 16'hFFFF || fatal_error_count == 16'h0000)
		else $error("fatal count left its maximum");
	a_single_cause: assert property (
		corrected_error_count == $past(corrected_error_count) + 16'h1
		|-> $past(frame_valid && frame_single_err) || $past(frame_valid && frame_single_err, 2))
		else $error("corrected count rose without a frame");
	a_fatal_cause: assert property (
		fatal_error_count == $past(fatal_error_count) + 16'h1
		|-> $past(frame_valid && frame_fatal_err) || $past(frame_valid && frame_fatal_err, 2))
		else $error("fatal count rose without a frame");

	// ----------------------------------------
	// configuration load
	// ----------------------------------------
	a_prom_clk_idle: assert property (config_ready |-> !prom_clk)
		else $error("prom clock runs while ready");
	a_load_ends_high: assert property ($rose(config_ready) |-> $past(prom_clk))
		else $error("ready rose outside a prom clock phase");
endmodule

bind rxrb_core rxrb_core_assertions #(.PROM_HALF(PROM_HALF), .DELAY_TAPS(DELAY_TAPS)) chk (
	.clk, .reset_n, .prom_clk, .frame_valid, .frame_is_bcast, .frame_ext, .frame_subaddr,
	.frame_data, .frame_single_err, .frame_fatal_err, .config_ready, .bcast_bus, .user_bcast,
	.bcast_strobe_a, .delayed_trigger, .crossing_count, .trigger_count, .corrected_error_count,
	.fatal_error_count, .data_out, .data_qual, .out_subaddress, .out_byte_strobe
);

// ==== testbench/rxrb_prom_model.sv ====
// serial configuration memory model
module rxrb_prom_model #(
	parameter logic [65:0] WORD = 66'h0
) (
	input wire prom_reset,
	input wire prom_clk,
	output logic prom_data = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned idx_q;

	// top bit first; a spent or reset memory shows the inverse of its last bit
	always @(posedge prom_clk or posedge prom_reset) begin
		if (prom_reset) begin
			idx_q <= 0;
			prom_data <= ~prom_data;
		end else if (idx_q < 66) begin
			prom_data <= WORD[65 - idx_q];
			idx_q <= idx_q + 1;
		end else begin
			prom_data <= ~prom_data;
		end
	end
endmodule

// ==== testbench/rxrb_core_test.sv ====
// self-checking bench for the receiver register bank
module rxrb_core_test;
	timeunit 1ns;
	timeprecision 1ps;
	// recommended fields, reinit and clock b enabled, id arbitrary
	localparam logic [65:0] CFG_WORD = {5'h01, 1'h1, 1'h0, 1'h0, 5'h1E, 4'hF, 4'hF, 2'h1,
		5'h1D, 5'h1D, 1'h1, 5'h1D, 3'h0, 3'h0, 5'h10, 1'h1, 1'h1, 14'h1A5C};
	logic clk = 1'b0, reset_n = 1'b0, frame_valid = 1'b0, frame_is_bcast = 1'b0;
	logic frame_ext = 1'b0, frame_single_err = 1'b0, frame_fatal_err = 1'b0;
	logic trigger_accept = 1'b0;
	logic [7:0] frame_bcast_data = 8'h00, frame_subaddr = 8'h00, frame_data = 8'h00;
	logic prom_data, prom_reset, prom_clk, config_ready, hamming_enable;
	logic phased_clock_b_enable, raw_clock_enable, serial_bus_enable;
	logic bcast_strobe_a, bcast_strobe_b, delayed_trigger, out_byte_strobe;
	logic [13:0] rx_id;
	logic [7:0] fine_delay_a, fine_delay_b, data_out, out_subaddress;
	logic [5:0] bcast_bus;
	logic [1:0] user_bcast;
	logic [11:0] crossing_count;
	logic [23:0] trigger_count;
	logic [15:0] corrected_error_count, fatal_error_count;
	logic [3:0] data_qual;
	logic [7:0] cfg_exp [8] = '{8'h3C, 8'hA5, 8'h21, 8'h83,
		CFG_WORD[7:0], CFG_WORD[15:8], CFG_WORD[23:16], CFG_WORD[31:24]};
	int err_total = 0;
	int cmp_count = 0;

	rxrb_core #(.PROM_HALF(3)) uut (.clk, .reset_n, .prom_data, .prom_reset, .prom_clk,
		.frame_valid, .frame_is_bcast, .frame_bcast_data, .frame_ext, .frame_subaddr,
		.frame_data, .frame_single_err, .frame_fatal_err, .trigger_accept, .config_ready,
		.rx_id, .hamming_enable, .phased_clock_b_enable, .raw_clock_enable,
		.serial_bus_enable, .fine_delay_a, .fine_delay_b, .bcast_bus, .user_bcast,
		.bcast_strobe_a, .bcast_strobe_b, .delayed_trigger, .crossing_count, .trigger_count,
		.corrected_error_count, .fatal_error_count, .data_out, .data_qual, .out_subaddress,
		.out_byte_strobe);
	rxrb_prom_model #(.WORD(CFG_WORD)) prom (.prom_reset, .prom_clk, .prom_data);

	// 100 MHz clock
	always #5 clk = ~clk;

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic report_and_stop();
		if (err_total == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_byte(input logic [7:0] exp, input logic [3:0] qual);
		cmp_count++;
		if ({out_byte_strobe, data_qual, data_out} !== {1'b1, qual, exp}) begin
			err_total++;
			$display("Error at %0t: dump byte %h qual %h", $time, data_out, data_qual);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic send(input logic bc, input logic [7:0] bd, input logic ext,
		input logic [7:0] sub, input logic [7:0] dat, input logic [1:0] err);
		@(posedge clk);
		frame_valid <= 1'b1;
		frame_is_bcast <= bc;
		frame_bcast_data <= bd;
		frame_ext <= ext;
		frame_subaddr <= sub;
		frame_data <= dat;
		{frame_single_err, frame_fatal_err} <= err;
		@(posedge clk);
		frame_valid <= 1'b0;
		{frame_single_err, frame_fatal_err} <= 2'h0;
	endtask
	task automatic wait_ready();
		int i;
		i = 0;
		while (config_ready !== 1'b1 && i < 3000) begin
			@(posedge clk);
			i++;
		end
		if (i >= 3000) begin
			err_total++;
			$display("Error at %0t: configuration load timed out", $time);
			report_and_stop();
		end
		step(1);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		step(7);
		chk_val({raw_clock_enable, serial_bus_enable, fine_delay_a}, 10'h200);
		@(posedge clk);
		reset_n <= 1'b1;
		wait_ready();
		chk_val({rx_id, hamming_enable, phased_clock_b_enable}, {14'h1A5C, 2'h3});
		// internal writes, one to an unmapped place
		send(1'b0, 8'h00, 1'b0, 8'h00, 8'h3C, 2'h0);
		send(1'b0, 8'h00, 1'b0, 8'h01, 8'hA5, 2'h0);
		send(1'b0, 8'h00, 1'b0, 8'h02, 8'h21, 2'h0);
		send(1'b0, 8'h00, 1'b0, 8'h04, 8'h99, 2'h0);
		step(2);
		chk_val({fine_delay_a, fine_delay_b}, 16'h3CA5);
		// configuration dump with coarse delays 1 and 2; strobe a leads the first byte
		send(1'b1, 8'hC8, 1'b0, 8'h00, 8'h00, 2'h0);
		step(2);
		chk_val({bcast_strobe_a, bcast_strobe_b}, 2'h2);
		chk_val({user_bcast, bcast_bus}, 8'hF2);
		step(1);
		for (int i = 0; i < 8; i++) begin
			chk_byte(cfg_exp[i], 4'(i + 5));
			if (i == 0) chk_val(bcast_strobe_b, 1'b1);
			step(1);
		end
		// corrected frame acted on, fatal frame dropped
		send(1'b0, 8'h00, 1'b0, 8'h00, 8'h77, 2'h2);
		send(1'b0, 8'h00, 1'b0, 8'h00, 8'h11, 2'h1);
		step(2);
		chk_val(fine_delay_a, 8'h77);
		chk_val({corrected_error_count, fatal_error_count}, 32'h0001_0001);
		// error dump combined with crossing clear
		send(1'b1, 8'h45, 1'b0, 8'h00, 8'h00, 2'h0);
		step(2);
		chk_val(crossing_count, 12'h000);
		step(1);
		chk_val(user_bcast, 2'h1);
		for (int i = 0; i < 4; i++) begin
			chk_byte(i[0] ? 8'h01 : 8'h00, 4'(i + 1));
			step(1);
		end
		chk_val(crossing_count, 12'h005);
		// triggers, then trigger clear and both clear
		repeat (3) begin
			@(posedge clk);
			trigger_accept <= 1'b1;
			@(posedge clk);
			trigger_accept <= 1'b0;
		end
		step(6);
		chk_val(trigger_count, 24'h3);
		send(1'b1, 8'h02, 1'b0, 8'h00, 8'h00, 2'h0);
		step(3);
		chk_val(trigger_count, 24'h0);
		send(1'b1, 8'h03, 1'b0, 8'h00, 8'h00, 2'h0);
		step(3);
		chk_val(crossing_count, 12'h001);
		// external byte looked at while its strobe stands, then bus forced off
		send(1'b0, 8'h00, 1'b1, 8'h5A, 8'hC3, 2'h0);
		step(0);
		chk_val({out_byte_strobe, data_qual, out_subaddress, data_out}, 21'h105AC3);
		send(1'b0, 8'h00, 1'b0, 8'h03, 8'hE3, 2'h0);
		send(1'b0, 8'h00, 1'b1, 8'h5A, 8'hC3, 2'h0);
		step(0);
		chk_val(serial_bus_enable, 1'b1);
		chk_val({out_byte_strobe, out_subaddress, data_out}, 17'h00000);
		// warm restart reloads the word and clears the state
		send(1'b1, 8'h10, 1'b0, 8'h00, 8'h00, 2'h0);
		step(10);
		chk_val(config_ready, 1'b0);
		wait_ready();
		chk_val({rx_id, serial_bus_enable, fine_delay_a}, {14'h1A5C, 9'h000});
		chk_val({corrected_error_count, fatal_error_count}, 32'h0);
		// single-error reinit armed by control bit 3; clear beats the count
		send(1'b0, 8'h00, 1'b0, 8'h03, 8'h8B, 2'h0);
		send(1'b0, 8'h00, 1'b0, 8'h00, 8'h00, 2'h2);
		step(2);
		chk_val({config_ready, corrected_error_count}, 17'h00000);
		wait_ready();
		report_and_stop();
	end
endmodule
